// ===== core/sleep_ctrl.sv
// Sleep mode controller with per-peripheral clock gating
module sleep_ctrl (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ctrl_we,
    input  wire logic [7:0]          ctrl_wdata,
    output logic [7:0]               sleep_control_reg,
    input  wire logic                stop_we,
    input  wire logic [7:0]          stop_wdata,
    output logic [7:0]               peripheral_clock_stop_reg,
    input  wire logic                sleep_instr,
    input  wire logic                crystal_option,
    input  wire logic                global_irq_en,
    input  wire logic [1:0]          slow_timer_irq_mask,
    input  wire logic                slow_timer_async,
    input  wire logic                slow_timer_enabled,
    input  wire logic                conv_enabled,
    input  wire sleep_pkg::wake_src_t wake_src,
    input  wire logic [sleep_pkg::CNT_W-1:0] startup_cycles,
    output sleep_pkg::clk_en_t       clk_en,
    output logic [7:0]               periph_clk_en,
    output logic                     slow_timer_run,
    output logic                     conv_start,
    output logic                     sleeping,
    output logic                     core_halt,
    output logic                     wake_pulse
);

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_STARTUP,
        ST_HALT
    } state_t;

    state_t                    state_r;
    sleep_pkg::sleep_mode_t    mode_r;
    sleep_pkg::sleep_mode_t    mode_nxt;
    logic [sleep_pkg::CNT_W-1:0] cnt_r;
    logic                      wake_req;
    logic [2:0]                sel;
    logic                      ext_lvl;

    assign sel     = sleep_control_reg[sleep_pkg::SEL_MSB:sleep_pkg::SEL_LSB];
    assign ext_lvl = (wake_src.ext_a & wake_src.ext_a_level) | (wake_src.ext_b & wake_src.ext_b_level);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Sleep control register, reserved bits held at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_control_reg <= sleep_pkg::CTRL_RESET;
        end else if (ctrl_we) begin
            sleep_control_reg <= ctrl_wdata & sleep_pkg::CTRL_MASK;
        end
    end

    // Peripheral clock stop register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peripheral_clock_stop_reg <= sleep_pkg::STOP_RESET;
        end else if (stop_we) begin
            peripheral_clock_stop_reg <= stop_wdata & sleep_pkg::STOP_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    // Map select field to a mode; reserved codes fall back to Idle
    always_comb begin
        case (sel)
            sleep_pkg::SEL_IDLE:    mode_nxt = sleep_pkg::MODE_IDLE;
            sleep_pkg::SEL_NOISE:   mode_nxt = sleep_pkg::MODE_NOISE;
            sleep_pkg::SEL_PDOWN:   mode_nxt = sleep_pkg::MODE_PDOWN;
            sleep_pkg::SEL_PSAVE:   mode_nxt = sleep_pkg::MODE_PSAVE;
            sleep_pkg::SEL_STANDBY: mode_nxt = crystal_option ? sleep_pkg::MODE_STANDBY
                                                              : sleep_pkg::MODE_IDLE;
            default:                mode_nxt = sleep_pkg::MODE_IDLE;
        endcase
    end

    // Wake qualification per mode
    always_comb begin
        case (mode_r)
            sleep_pkg::MODE_IDLE: begin
                wake_req = wake_src.ext_a | wake_src.ext_b | wake_src.pin_change | wake_src.two_wire_match
                         | wake_src.slow_timer_ovf | wake_src.slow_timer_cmp | wake_src.store_ready
                         | wake_src.conv_done | wake_src.watchdog | wake_src.other_irq;
            end
            sleep_pkg::MODE_NOISE: begin
                wake_req = ext_lvl | wake_src.pin_change | wake_src.two_wire_match | wake_src.watchdog
                         | wake_src.store_ready | wake_src.conv_done
                         | (slow_timer_async & (wake_src.slow_timer_ovf | wake_src.slow_timer_cmp));
            end
            sleep_pkg::MODE_PSAVE: begin
                wake_req = ext_lvl | wake_src.pin_change | wake_src.two_wire_match | wake_src.watchdog
                         | (global_irq_en & ((wake_src.slow_timer_ovf & slow_timer_irq_mask[0])
                         | (wake_src.slow_timer_cmp & slow_timer_irq_mask[1])));
            end
            default: begin
                wake_req = ext_lvl | wake_src.pin_change | wake_src.two_wire_match | wake_src.watchdog;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer; reset always returns to active, core restarts at reset vector

    // Sleep entry, wake start-up count and post-wake halt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_ACTIVE;
            mode_r  <= sleep_pkg::MODE_IDLE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ST_ACTIVE: begin
                    if (sleep_instr && sleep_control_reg[sleep_pkg::ARM_BIT]) begin
                        state_r <= ST_SLEEP;
                        mode_r  <= mode_nxt;
                    end
                end
                ST_SLEEP: begin
                    if (wake_req) begin
                        state_r <= ST_STARTUP;
                        if (mode_r == sleep_pkg::MODE_STANDBY) begin
                            cnt_r <= sleep_pkg::CNT_W'(sleep_pkg::STANDBY_CYCLES - 1);
                        end else if (mode_r == sleep_pkg::MODE_PDOWN || mode_r == sleep_pkg::MODE_PSAVE) begin
                            cnt_r <= startup_cycles;
                        end else begin
                            cnt_r <= '0;
                        end
                    end
                end
                ST_STARTUP: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_HALT;
                        cnt_r   <= sleep_pkg::CNT_W'(sleep_pkg::HALT_CYCLES - 1);
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_HALT: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_ACTIVE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: state_r <= ST_ACTIVE;
            endcase
        end
    end

    // One-cycle wake pulse as the core resumes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= (state_r == ST_HALT) && (cnt_r == '0);
        end
    end

    // Conversion start on entry to Idle or noise reduction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= (state_r == ST_ACTIVE) && sleep_instr && sleep_control_reg[sleep_pkg::ARM_BIT]
                        && conv_enabled && (mode_nxt == sleep_pkg::MODE_IDLE
                        || mode_nxt == sleep_pkg::MODE_NOISE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock gating; gating only stops clocks, so storage keeps its contents

    logic asleep;
    assign asleep    = (state_r == ST_SLEEP) || (state_r == ST_STARTUP);
    assign sleeping  = asleep;
    assign core_halt = (state_r != ST_ACTIVE);

    // Domain enables per mode
    always_comb begin
        clk_en = '1;
        slow_timer_run = slow_timer_enabled;
        if (asleep) begin
            case (mode_r)
                sleep_pkg::MODE_IDLE: begin
                    clk_en.cpu   = 1'b0;
                    clk_en.flash = 1'b0;
                end
                sleep_pkg::MODE_NOISE: begin
                    clk_en.cpu   = 1'b0;
                    clk_en.flash = 1'b0;
                    clk_en.io    = 1'b0;
                    clk_en.timer_osc = slow_timer_async;
                    slow_timer_run = slow_timer_enabled & slow_timer_async;
                end
                sleep_pkg::MODE_PSAVE: begin
                    clk_en = '0;
                    clk_en.asy       = slow_timer_enabled & slow_timer_async;
                    clk_en.timer_osc = slow_timer_enabled & slow_timer_async;
                    clk_en.main_osc  = slow_timer_enabled & ~slow_timer_async;
                    slow_timer_run   = slow_timer_enabled & slow_timer_async;
                end
                sleep_pkg::MODE_STANDBY: begin
                    clk_en = '0;
                    clk_en.main_osc = 1'b1;
                    slow_timer_run  = 1'b0;
                end
                default: begin
                    clk_en = '0;
                    slow_timer_run = 1'b0;
                end
            endcase
        end
    end

    // Per-peripheral enables, effective in Active and Idle only
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_periph
            assign periph_clk_en[g] = sleep_pkg::STOP_MASK[g] & ~peripheral_clock_stop_reg[g]
                                    & (~asleep | (mode_r == sleep_pkg::MODE_IDLE));
        end
    endgenerate

endmodule : sleep_ctrl

// ===== core/sleep_pkg.sv
// Constants, types and the contract list of the sleep and clock gating controller
//
// Contract
// - Sleep happens only when arm bit set and sleep instruction executes.
// - Select 000 Idle: stop core and program-memory clocks, rest runs.
// - Select 001 noise reduction: stop I/O, core, program-memory clocks.
// - Select 010 Power-down: oscillator and all generated clocks stopped.
// - Select 011 Power-save: as Power-down, async timer keeps running.
// - Select 110 with crystal option: Standby, oscillator runs, wake in six cycles.
// - Enabled interrupt wakes; core held four cycles beyond start-up time.
// - Waking leaves register file and RAM contents unchanged.
// - Reset during sleep wakes and starts from the reset vector.
// - Idle and noise reduction start a conversion if converter enabled.
// - Noise reduction wakes only from its listed sources.
// - Power-down wakes only from its listed sources.
// - Outside Idle, external interrupt pins wake only when level sensed.
// - Power-down wake waits the fuse-defined start-up period.
// - Power-save timer wake needs its mask bit and global enable.
// - Power-save stops unused timer oscillator or main clock.
// - Noise reduction and Power-save: timer counts only when asynchronous.
// - Setting a clock stop bit stops that peripheral's clock and access.
// - Clearing the bit restarts the clock, state preserved.
// - Per-peripheral stop acts in Active and Idle only.
// - Control reg: arm bit 0, select bits 3..1, bits 7..4 zero.
// - Stop reg bits: 7 two-wire, 6,5,3 timers, 2 serial, 1 transceiver, 0 converter.
package sleep_pkg;

    localparam int unsigned ARM_BIT        = 0;
    localparam int unsigned SEL_LSB        = 1;
    localparam int unsigned SEL_MSB        = 3;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  CTRL_MASK      = 8'h0F;
    localparam logic [7:0]  STOP_RESET     = 8'h00;
    localparam logic [7:0]  STOP_MASK      = 8'hEF;

    localparam int unsigned STOP_TWO_WIRE  = 7;
    localparam int unsigned STOP_SLOW_TMR  = 6;
    localparam int unsigned STOP_TIMER_A   = 5;
    localparam int unsigned STOP_TIMER_B   = 3;
    localparam int unsigned STOP_SERIAL    = 2;
    localparam int unsigned STOP_XCVR      = 1;
    localparam int unsigned STOP_CONV      = 0;

    localparam logic [2:0]  SEL_IDLE       = 3'h0;
    localparam logic [2:0]  SEL_NOISE      = 3'h1;
    localparam logic [2:0]  SEL_PDOWN      = 3'h2;
    localparam logic [2:0]  SEL_PSAVE      = 3'h3;
    localparam logic [2:0]  SEL_STANDBY    = 3'h6;

    localparam int unsigned HALT_CYCLES    = 4;
    localparam int unsigned STANDBY_CYCLES = 6;
    localparam int unsigned CNT_W          = 20;

    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_NOISE,
        MODE_PDOWN,
        MODE_PSAVE,
        MODE_STANDBY
    } sleep_mode_t;

    // Clock domain enables
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } clk_en_t;

    // Wake request sources
    typedef struct packed {
        logic ext_a;
        logic ext_b;
        logic ext_a_level;
        logic ext_b_level;
        logic pin_change;
        logic two_wire_match;
        logic slow_timer_ovf;
        logic slow_timer_cmp;
        logic store_ready;
        logic conv_done;
        logic watchdog;
        logic other_irq;
    } wake_src_t;

endpackage : sleep_pkg

// ===== sim/sleep_core_model.sv
// Core and interrupt-source model facing the sleep controller
module sleep_core_model (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 go,
    input wire sleep_pkg::wake_src_t req,
    input wire logic                 cancel,
    input wire logic                 wake_pulse,
    output sleep_pkg::wake_src_t     wake_src,
    output logic                     sleep_instr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Core executes the sleep instruction as a one-cycle pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sleep_instr <= 1'b0;
        else sleep_instr <= go;
    end
    // Sources hold their level until the core resumes or cancel clears them, so a level wake is not lost before then
    always_ff @(posedge clk or posedge rst) begin
        if (rst) wake_src <= '0;
        else if (cancel || wake_pulse) wake_src <= '0;
        else wake_src <= wake_src | req;
    end
endmodule : sleep_core_model

// ===== sim/sleep_ctrl_properties.sv
// Port checker for the sleep controller
module sleep_ctrl_checker (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic [7:0]         sleep_control_reg,
    input wire logic [7:0]         peripheral_clock_stop_reg,
    input wire logic               sleep_instr,
    input wire logic               crystal_option,
    input wire logic               conv_enabled,
    input wire sleep_pkg::clk_en_t clk_en,
    input wire logic [7:0]         periph_clk_en,
    input wire logic               conv_start,
    input wire logic               sleeping,
    input wire logic               core_halt,
    input wire logic               wake_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Accepted sleep request and the select it latches
    logic       go;
    logic [2:0] sel;
    assign go  = sleep_instr && !core_halt && sleep_control_reg[0];
    assign sel = sleep_control_reg[3:1];
    // Four halted cycles, then resume with one pulse
    sequence halt_tail;
        core_halt [*4] ##1 (!core_halt && wake_pulse);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_arm_gate: assert property (sleep_instr && !core_halt && !sleep_control_reg[0] |=> !sleeping)
        else $error("sleep without arm");
    chk_sleep_entry: assert property (go |=> sleeping && core_halt && !clk_en.cpu && !clk_en.flash)
        else $error("sleep entry wrong");
    chk_idle_clks: assert property (go && sel == sleep_pkg::SEL_IDLE |=> clk_en.io && clk_en.adc && clk_en.asy)
        else $error("idle clocks wrong");
    chk_noise_clks: assert property (go && sel == sleep_pkg::SEL_NOISE |=> !clk_en.io && clk_en.adc)
        else $error("noise clocks wrong");
    chk_pdown_clks: assert property (go && sel == sleep_pkg::SEL_PDOWN |=> !(clk_en.io || clk_en.main_osc))
        else $error("power-down clocks wrong");
    chk_standby_osc: assert property (go && sel == sleep_pkg::SEL_STANDBY && crystal_option |=> clk_en.main_osc)
        else $error("standby oscillator stopped");
    chk_reserved_idle: assert property (go && sel[2] && !(sel[1:0] == 2'h2 && crystal_option) |=> clk_en.io)
        else $error("reserved select not idle");
    chk_conv_auto: assert property (go && conv_enabled && sel == sleep_pkg::SEL_IDLE |=> conv_start)
        else $error("no conversion on entry");
    chk_halt_tail: assert property ($fell(sleeping) |-> halt_tail)
        else $error("wake halt sequence wrong");
    chk_periph_gate: assert property (!core_halt |-> periph_clk_en == (~peripheral_clock_stop_reg & 8'hEF))
        else $error("peripheral enables wrong");
endmodule : sleep_ctrl_checker

bind sleep_ctrl sleep_ctrl_checker chk_u (.clk(clk), .rst(rst), .sleep_control_reg(sleep_control_reg),
    .peripheral_clock_stop_reg(peripheral_clock_stop_reg), .sleep_instr(sleep_instr),
    .crystal_option(crystal_option), .conv_enabled(conv_enabled), .clk_en(clk_en), .periph_clk_en(periph_clk_en),
    .conv_start(conv_start), .sleeping(sleeping), .core_halt(core_halt), .wake_pulse(wake_pulse));

// ===== sim/sleep_ctrl_tb_top.sv
// Self-checking bench for the sleep controller
module sleep_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [2:0] sel;
        logic       xtal;
        logic [7:0] clks;
        logic       conv;
        int         lat;
    } row_t;
    // Select, crystal, {all clock enables, timer run}, conversion, wake latency (deep: 7 + start-up 3)
    row_t rows [7] = '{
        '{3'h0, 1'b0, 8'h3F, 1'b1, 7}, '{3'h1, 1'b0, 8'h1F, 1'b1, 7}, '{3'h2, 1'b0, 8'h00, 1'b0, 10},
        '{3'h3, 1'b0, 8'h0B, 1'b0, 10}, '{3'h6, 1'b1, 8'h04, 1'b0, 12}, '{3'h4, 1'b0, 8'h3F, 1'b1, 7},
        '{3'h6, 1'b0, 8'h3F, 1'b1, 7}};
    // Converter starts disabled so its clock may be stopped safely
    logic clk = 1'b0, rst = 1'b1, ctrl_we = 1'b0, stop_we = 1'b0, go = 1'b0, cancel = 1'b0, conv_enabled = 1'b0;
    logic crystal_option = 1'b0, global_irq_en = 1'b1, slow_timer_async = 1'b1, slow_timer_enabled = 1'b1;
    logic [7:0]           ctrl_wdata = 8'h00, stop_wdata = 8'h00, sleep_control_reg, peripheral_clock_stop_reg;
    logic [7:0]           periph_clk_en;
    logic [1:0]           slow_timer_irq_mask = 2'h0;
    logic [sleep_pkg::CNT_W-1:0] startup = 20'h00003;
    logic                 sleep_instr, slow_timer_run, conv_start, sleeping, core_halt, wake_pulse;
    sleep_pkg::wake_src_t req = '0, wake_src, dog = '{watchdog: 1'b1, default: 1'b0};
    sleep_pkg::clk_en_t   clk_en;
    int                   error_cnt = 0, checked = 0, n = 0;
    ////////////////////////////////////////////////////////////////////////////////
    sleep_ctrl dut_u (
        .clk(clk), .rst(rst), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .sleep_control_reg(sleep_control_reg),
        .stop_we(stop_we), .stop_wdata(stop_wdata), .peripheral_clock_stop_reg(peripheral_clock_stop_reg),
        .sleep_instr(sleep_instr), .crystal_option(crystal_option), .global_irq_en(global_irq_en),
        .slow_timer_irq_mask(slow_timer_irq_mask), .slow_timer_async(slow_timer_async),
        .slow_timer_enabled(slow_timer_enabled), .conv_enabled(conv_enabled), .wake_src(wake_src),
        .startup_cycles(startup), .clk_en(clk_en), .periph_clk_en(periph_clk_en), .slow_timer_run(slow_timer_run),
        .conv_start(conv_start), .sleeping(sleeping), .core_halt(core_halt), .wake_pulse(wake_pulse));
    sleep_core_model core_u (.clk(clk), .rst(rst), .go(go), .req(req), .cancel(cancel), .wake_pulse(wake_pulse),
        .wake_src(wake_src), .sleep_instr(sleep_instr));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // One-cycle write to the control register or the clock stop register
    task automatic wr(input logic to_ctrl, input logic [7:0] v);
        @(posedge clk);
        ctrl_we    <= to_ctrl;
        stop_we    <= !to_ctrl;
        ctrl_wdata <= v;
        stop_wdata <= v;
        @(posedge clk);
        ctrl_we <= 1'b0;
        stop_we <= 1'b0;
        #1;
    endtask : wr
    // Arm and select, then let the core run the sleep instruction
    task automatic enter(input logic [2:0] sel, input logic arm);
        wr(1'b1, {4'h0, sel, arm});
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask : enter
    // Raise a source and count edges until the resume pulse
    task automatic wake(input sleep_pkg::wake_src_t src);
        @(posedge clk);
        req <= src;
        @(posedge clk);
        req <= '0;
        #1;
        n = 1;
        while (wake_pulse !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wake
    // A source the mode must ignore, then a legal wake
    task automatic refuse(input logic [2:0] sel, input sleep_pkg::wake_src_t src);
        enter(sel, 1'b1);
        @(posedge clk);
        req <= src;
        @(posedge clk);
        req <= '0;
        repeat (30) @(posedge clk);
        #1;
        chk("held asleep", 1'b1, sleeping);
        @(posedge clk);
        cancel <= 1'b1;
        @(posedge clk);
        cancel <= 1'b0;
        wake(dog);
    endtask : refuse
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz
    initial begin
        forever #5 clk = ~clk;
    end
    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    // Reset, registers, mode table, refusals, reset in sleep
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset regs", 16'h0000, {sleep_control_reg, peripheral_clock_stop_reg});
        chk("periph reset", 8'hEF, periph_clk_en);
        wr(1'b1, 8'hFE);
        chk("ctrl bits", 8'h0E, sleep_control_reg);
        wr(1'b0, 8'hFF);
        chk("stop bits", 8'hEF, peripheral_clock_stop_reg);
        chk("periph off", 8'h00, periph_clk_en);
        wr(1'b0, 8'h01);
        chk("periph restart", 8'hEE, periph_clk_en);
        enter(sleep_pkg::SEL_IDLE, 1'b1);
        chk("periph idle", 8'hEE, periph_clk_en);
        wake(dog);
        enter(sleep_pkg::SEL_PDOWN, 1'b1);
        chk("periph deep", 8'h00, periph_clk_en);
        wake(dog);
        wr(1'b0, 8'h00);
        enter(sleep_pkg::SEL_IDLE, 1'b0);
        chk("unarmed sleep", 1'b0, sleeping);
        @(posedge clk);
        conv_enabled <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            crystal_option <= rows[i].xtal;
            enter(rows[i].sel, 1'b1);
            chk("mode clocks", rows[i].clks, {clk_en, slow_timer_run});
            chk("conv start", rows[i].conv, conv_start);
            wake(dog);
            chk("wake latency", rows[i].lat, n);
        end
        refuse(sleep_pkg::SEL_NOISE, '{other_irq: 1'b1, default: 1'b0});
        refuse(sleep_pkg::SEL_PDOWN, '{conv_done: 1'b1, default: 1'b0});
        refuse(sleep_pkg::SEL_PDOWN, '{ext_a: 1'b1, default: 1'b0});
        refuse(sleep_pkg::SEL_PSAVE, '{slow_timer_ovf: 1'b1, default: 1'b0});
        enter(sleep_pkg::SEL_PDOWN, 1'b1);
        wake('{ext_b: 1'b1, ext_b_level: 1'b1, default: 1'b0});
        chk("level wake", 10, n);
        // Longer fuse start-up count, masked timer wake
        @(posedge clk);
        slow_timer_irq_mask <= 2'h1;
        startup             <= 20'h00005;
        enter(sleep_pkg::SEL_PSAVE, 1'b1);
        wake('{slow_timer_ovf: 1'b1, default: 1'b0});
        chk("timer wake", 12, n);
        // Global enable off blocks the timer wake
        @(posedge clk);
        global_irq_en <= 1'b0;
        refuse(sleep_pkg::SEL_PSAVE, '{slow_timer_ovf: 1'b1, default: 1'b0});
        // Timer on the synchronous clock
        @(posedge clk);
        global_irq_en    <= 1'b1;
        slow_timer_async <= 1'b0;
        enter(sleep_pkg::SEL_NOISE, 1'b1);
        chk("sync noise", 8'h1C, {clk_en, slow_timer_run});
        wake(dog);
        enter(sleep_pkg::SEL_PSAVE, 1'b1);
        chk("sync save", 8'h04, {clk_en, slow_timer_run});
        wake(dog);
        enter(sleep_pkg::SEL_PDOWN, 1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset wakes", 3'h0, {sleeping, core_halt, sleep_control_reg[0]});
        final_report();
    end
endmodule : sleep_ctrl_tb_top
